// *** cfg_byte_reg.sv ***
/*
 * One 8-bit configuration register with a power-on value and a mask of
 * writable bits; masked-off bits keep their reset value for ever.
 * Assumes the write strobe is a single-cycle commit from the bus slave.
 */
`default_nettype none

module cfg_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hff
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);

    logic [7:0] val_ff;
    logic [7:0] nxt_val;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Writes merge only the writable bits
    always_comb begin
        nxt_val = val_ff;
        if (wr_en) begin
            nxt_val = (wdata & WR_MASK) | (RESET_VAL & ~WR_MASK);
        end
    end

    // Default loaded under reset, before any bus access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_ff <= RESET_VAL;
        end else begin
            val_ff <= nxt_val;
        end
    end

    assign q = val_ff;

    // Fixed bits never move, whatever software writes
    property p_fixed_bits;
        @(posedge pclk) disable iff (!presetn)
        ((val_ff & ~WR_MASK) == (RESET_VAL & ~WR_MASK));
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("fixed register bits changed");

endmodule

`default_nettype wire

// *** cfg_regs_pkg.sv ***
/*
 * Constants for the filter and oversampling clock configuration bank:
 * register indices, byte addresses, reset values, field positions and codes.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
`default_nettype none

package cfg_regs_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_DECIM     = 8'h06;
    localparam logic [7:0]  IDX_FILT      = 8'h07;
    localparam logic [7:0]  IDX_CLK       = 8'h08;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_DECIM    = {2'h0, IDX_DECIM, 2'h0};
    localparam logic [11:0] ADDR_FILT     = {2'h0, IDX_FILT, 2'h0};
    localparam logic [11:0] ADDR_CLK      = {2'h0, IDX_CLK, 2'h0};

    // ------------------------------------------------------------------
    // Power-on values and writable bits
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_DECIM     = 8'hc5;
    localparam logic [7:0]  RST_FILT      = 8'h04;
    localparam logic [7:0]  RST_CLK       = 8'h20;
    localparam logic [7:0]  WMASK_DECIM   = 8'hff;
    localparam logic [7:0]  WMASK_FILT    = 8'hfe;
    localparam logic [7:0]  WMASK_CLK     = 8'hff;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          FILT_SEL_BIT  = 7;
    localparam int          DEPTH_LSB     = 3;
    localparam int          PATH_LSB      = 1;
    localparam int          OSC_SRC_LSB   = 6;
    localparam int          OSC_DIV_LSB   = 4;
    localparam int          OUT_SRC_LSB   = 2;

    // ------------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  DEPTH_BYPASS  = 4'h0;
    localparam logic [1:0]  PATH_DECHOP   = 2'h2;
    localparam logic [1:0]  SRC_HS_NOOUT  = 2'h0;
    localparam logic [1:0]  SRC_HS_OUT    = 2'h1;
    localparam logic [1:0]  SRC_EXT       = 2'h2;
    localparam logic [1:0]  DIV_BY_4      = 2'h2;
    localparam logic [1:0]  OUT_SRC_DEC2  = 2'h1;

    // APB slave phases, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_RESP   = 3'b100
    } apb_state_t;

endpackage

`default_nettype wire

// *** filter_and_clock_config_regs.sv ***
/*
 * Filter and oversampling clock configuration bank behind an APB slave.
 * What this file holds: the bus slave, three configuration registers and
 * the registered control outputs that steer the filter, measurement path,
 * output source selection and oversampling clock selection and divider.
 * Assumes: one clock pclk at 125 MHz, asynchronous active-low presetn,
 * a well-behaved APB master.
 */
// Added by the designer: the APB interface to the registers.
// What this block does
// - bit 7 picks averaging filter over FIR
// - bits 6..3 set averaging depth, zero bypasses
// - bits 2..1 choose measurement path arrangement
// - clock bits 7..6 choose oversampling clock source
// - clock bits 5..4 choose clock divide ratio
// - decimation bits 3..2 choose output data source
`default_nettype none

module filter_and_clock_config_regs
    import cfg_regs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   ma_filter_sel,
    output logic      [3:0]        ma_depth,
    output logic                   avg_bypass,
    output logic      [1:0]        meas_path,
    output logic      [1:0]        out_src_sel,
    output logic      [1:0]        osc_src_sel,
    output logic                   hs_clk_out_en,
    output logic                   ext_clk_sel,
    output logic      [1:0]        osc_div_sel,
    output logic      [3:0]        osc_div_factor
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Word address match; low two bits ignored as APB words are aligned
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] reg_addr);
        addr_hit = (a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2]);
    endfunction

    // Divide factor from a two-bit ratio code
    function automatic logic [3:0] div_factor(input logic [1:0] code);
        div_factor = 4'h1 << code;
    endfunction

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    apb_state_t  state_ff;
    apb_state_t  nxt_state;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        hit_decim;
    logic        hit_filt;
    logic        hit_clk;
    logic        commit;
    logic [7:0]  decim_q;
    logic [7:0]  filt_q;
    logic [7:0]  clk_q;

    assign hit_decim = addr_hit(paddr, ADDR_DECIM);
    assign hit_filt  = addr_hit(paddr, ADDR_FILT);
    assign hit_clk   = addr_hit(paddr, ADDR_CLK);
    // Write lands only at the edge where the master sees pready high
    assign commit    = (state_ff == ST_RESP) && psel && penable && pwrite;

    // One wait state lets read data and pready come straight from flops
    always_comb begin
        nxt_state   = state_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (psel && !penable) begin
                    nxt_state = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (psel && penable) begin
                    nxt_state   = ST_RESP;
                    nxt_pready  = 1'b1;
                    nxt_pslverr = !(hit_decim || hit_filt || hit_clk);
                    nxt_prdata  = 32'h0000_0000;
                    if (!pwrite) begin
                        if (hit_decim) begin
                            nxt_prdata = {24'h00_0000, decim_q};
                        end else if (hit_filt) begin
                            nxt_prdata = {24'h00_0000, filt_q};
                        end else if (hit_clk) begin
                            nxt_prdata = {24'h00_0000, clk_q};
                        end
                    end
                end
            end
            ST_RESP: begin
                // Back-to-back setup is accepted straight away
                nxt_state = (psel && !penable) ? ST_ACCESS : ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= ST_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            state_ff   <= nxt_state;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Reserved filter bit 0 is held at zero in hardware
    cfg_byte_reg #(.RESET_VAL(RST_DECIM), .WR_MASK(WMASK_DECIM)) decim_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (commit && hit_decim),
        .wdata   (pwdata[7:0]),
        .q       (decim_q)
    );

    cfg_byte_reg #(.RESET_VAL(RST_FILT), .WR_MASK(WMASK_FILT)) filt_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (commit && hit_filt),
        .wdata   (pwdata[7:0]),
        .q       (filt_q)
    );

    cfg_byte_reg #(.RESET_VAL(RST_CLK), .WR_MASK(WMASK_CLK)) clk_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (commit && hit_clk),
        .wdata   (pwdata[7:0]),
        .q       (clk_q)
    );

    // ------------------------------------------------------------------
    // Decoded control outputs
    // ------------------------------------------------------------------
    logic       ma_sel_ff,   nxt_ma_sel;
    logic [3:0] depth_ff,    nxt_depth;
    logic       bypass_ff,   nxt_bypass;
    logic [1:0] path_ff,     nxt_path;
    logic [1:0] out_src_ff,  nxt_out_src;
    logic [1:0] src_ff,      nxt_src;
    logic       clk_out_ff,  nxt_clk_out;
    logic       ext_ff,      nxt_ext;
    logic [1:0] div_ff,      nxt_div;
    logic [3:0] factor_ff,   nxt_factor;

    // Outputs trail the register contents by one cycle to stay glitch free
    always_comb begin
        nxt_ma_sel  = filt_q[FILT_SEL_BIT];
        nxt_depth   = filt_q[DEPTH_LSB +: 4];
        nxt_bypass  = (filt_q[DEPTH_LSB +: 4] == DEPTH_BYPASS);
        nxt_path    = filt_q[PATH_LSB +: 2];
        nxt_out_src = decim_q[OUT_SRC_LSB +: 2];
        nxt_src     = clk_q[OSC_SRC_LSB +: 2];
        nxt_clk_out = (clk_q[OSC_SRC_LSB +: 2] == SRC_HS_OUT);
        nxt_ext     = (clk_q[OSC_SRC_LSB +: 2] == SRC_EXT);
        nxt_div     = clk_q[OSC_DIV_LSB +: 2];
        nxt_factor  = div_factor(clk_q[OSC_DIV_LSB +: 2]);
    end

    // Reset values match the power-on register contents
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ma_sel_ff  <= RST_FILT[FILT_SEL_BIT];
            depth_ff   <= RST_FILT[DEPTH_LSB +: 4];
            bypass_ff  <= 1'b1;
            path_ff    <= RST_FILT[PATH_LSB +: 2];
            out_src_ff <= RST_DECIM[OUT_SRC_LSB +: 2];
            src_ff     <= RST_CLK[OSC_SRC_LSB +: 2];
            clk_out_ff <= 1'b0;
            ext_ff     <= 1'b0;
            div_ff     <= RST_CLK[OSC_DIV_LSB +: 2];
            factor_ff  <= 4'h4;
        end else begin
            ma_sel_ff  <= nxt_ma_sel;
            depth_ff   <= nxt_depth;
            bypass_ff  <= nxt_bypass;
            path_ff    <= nxt_path;
            out_src_ff <= nxt_out_src;
            src_ff     <= nxt_src;
            clk_out_ff <= nxt_clk_out;
            ext_ff     <= nxt_ext;
            div_ff     <= nxt_div;
            factor_ff  <= nxt_factor;
        end
    end

    assign ma_filter_sel  = ma_sel_ff;
    assign ma_depth       = depth_ff;
    assign avg_bypass     = bypass_ff;
    assign meas_path      = path_ff;
    assign out_src_sel    = out_src_ff;
    assign osc_src_sel    = src_ff;
    assign hs_clk_out_en  = clk_out_ff;
    assign ext_clk_sel    = ext_ff;
    assign osc_div_sel    = div_ff;
    assign osc_div_factor = factor_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic       wd_sel;
    logic [3:0] wd_depth;
    logic [1:0] wd_path;
    logic [1:0] wd_out_src;
    logic [1:0] wd_src;
    logic [1:0] wd_div;

    assign wd_sel     = pwdata[FILT_SEL_BIT];
    assign wd_depth   = pwdata[DEPTH_LSB +: 4];
    assign wd_path    = pwdata[PATH_LSB +: 2];
    assign wd_out_src = pwdata[OUT_SRC_LSB +: 2];
    assign wd_src     = pwdata[OSC_SRC_LSB +: 2];
    assign wd_div     = pwdata[OSC_DIV_LSB +: 2];

    sequence s_wr_filt;
        commit && hit_filt;
    endsequence
    sequence s_wr_clk;
        commit && hit_clk;
    endsequence

    property p_filt_sel;
        @(posedge pclk) disable iff (!presetn)
        s_wr_filt |=> ##1 (ma_filter_sel == $past(wd_sel, 2));
    endproperty
    a_filt_sel: assert property (p_filt_sel)
        else $error("filter select did not follow write");

    property p_depth;
        @(posedge pclk) disable iff (!presetn)
        s_wr_filt |=> ##1 (ma_depth == $past(wd_depth, 2))
                          && (avg_bypass == (ma_depth == DEPTH_BYPASS));
    endproperty
    a_depth: assert property (p_depth)
        else $error("averaging depth or bypass wrong after write");

    property p_path;
        @(posedge pclk) disable iff (!presetn)
        s_wr_filt |=> ##1 (meas_path == $past(wd_path, 2));
    endproperty
    a_path: assert property (p_path)
        else $error("measurement path did not follow write");

    property p_src;
        @(posedge pclk) disable iff (!presetn)
        s_wr_clk |=> ##1 (osc_src_sel == $past(wd_src, 2))
                         && (hs_clk_out_en == (osc_src_sel == SRC_HS_OUT))
                         && (ext_clk_sel == (osc_src_sel == SRC_EXT));
    endproperty
    a_src: assert property (p_src)
        else $error("clock source decode wrong after write");

    property p_div;
        @(posedge pclk) disable iff (!presetn)
        s_wr_clk |=> ##1 (osc_div_sel == $past(wd_div, 2))
                         && (osc_div_factor == (4'h1 << osc_div_sel));
    endproperty
    a_div: assert property (p_div)
        else $error("clock divide ratio wrong after write");

    property p_out_src;
        @(posedge pclk) disable iff (!presetn)
        (commit && hit_decim) |=> ##1 (out_src_sel == $past(wd_out_src, 2));
    endproperty
    a_out_src: assert property (p_out_src)
        else $error("output source did not follow write");

    property p_reset_defaults;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (filt_q == RST_FILT) && (clk_q == RST_CLK)
                           && (decim_q == RST_DECIM) && !ma_filter_sel
                           && (meas_path == PATH_DECHOP) && (osc_div_sel == DIV_BY_4)
                           && (osc_src_sel == SRC_HS_NOOUT)
                           && (out_src_sel == OUT_SRC_DEC2);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("defaults not loaded at reset release");

    property p_one_wait;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == ST_IDLE && psel && !penable) ##1 (psel && penable)
            |=> pready ##1 !pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after exactly one wait state");

endmodule

`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for the filter and oversampling clock configuration
 * bank: APB read and write tasks plus directed register and control tests.
 * Assumes the package constants, a single 125 MHz clock and an APB slave
 * that answers with a one-cycle pready pulse.
 */
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (got), (exp)); end end

module testbench import cfg_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              ma_filter_sel;
    logic [3:0]        ma_depth;
    logic              avg_bypass;
    logic [1:0]        meas_path;
    logic [1:0]        out_src_sel;
    logic [1:0]        osc_src_sel;
    logic              hs_clk_out_en;
    logic              ext_clk_sel;
    logic [1:0]        osc_div_sel;
    logic [3:0]        osc_div_factor;
    int                num_errors;
    int                compares;
    int                cycles;
    logic [7:0]        v;
    logic [3:0]        depths [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

    filter_and_clock_config_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ma_filter_sel(ma_filter_sel),
        .ma_depth(ma_depth), .avg_bypass(avg_bypass), .meas_path(meas_path),
        .out_src_sel(out_src_sel), .osc_src_sel(osc_src_sel),
        .hs_clk_out_en(hs_clk_out_en), .ext_clk_sel(ext_clk_sel),
        .osc_div_sel(osc_div_sel), .osc_div_factor(osc_div_factor)
    );

    // Free-running 8 ns clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Hang guard, far above the two hundred or so cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("BAD t=%0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'hffffff, d}, rd, err);
        `CHK(err, exp_err)
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        `CHK(rd, exp)
        `CHK(err, exp_err)
    endtask

    // Control outputs lag the commit by two edges; allow a third for margin
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic chk_defaults();
        `CHK({ma_filter_sel, ma_depth, avg_bypass}, 6'h01)
        `CHK({meas_path, out_src_sel}, 4'h9)
        `CHK({osc_src_sel, hs_clk_out_en, ext_clk_sel}, 4'h0)
        `CHK({osc_div_sel, osc_div_factor}, 6'h24)
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        num_errors = 0;
        compares = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (2) @(posedge pclk);
        #1;
        chk_defaults();
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_DECIM, 32'h0000_00c5, 1'b0);
        rd_chk(ADDR_FILT, 32'h0000_0004, 1'b0);
        rd_chk(ADDR_CLK, 32'h0000_0020, 1'b0);
        #1;
        chk_defaults();

        // Filter select, depths 0, 1, 3, 7 and 15, and every path code; reserved bit 0 kept clear
        for (int i = 0; i < 5; i++) begin
            v = {i[0], depths[i], i[1:0], 1'b0};
            wr_reg(ADDR_FILT, v, 1'b0);
            rd_chk(ADDR_FILT, {24'h0, v & 8'hfe}, 1'b0);
            settle();
            `CHK(ma_filter_sel, v[7])
            `CHK(ma_depth, v[6:3])
            `CHK(avg_bypass, (v[6:3] == 4'h0))
            `CHK(meas_path, v[2:1])
        end

        // Every clock source and divider code, the unused code 11 as well
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], 2'(2 - i), 4'ha};
            wr_reg(ADDR_CLK, v, 1'b0);
            rd_chk(ADDR_CLK, {24'h0, v}, 1'b0);
            settle();
            `CHK(osc_src_sel, v[7:6])
            `CHK(hs_clk_out_en, (v[7:6] == 2'h1))
            `CHK(ext_clk_sel, (v[7:6] == 2'h2))
            `CHK(osc_div_sel, v[5:4])
            `CHK(osc_div_factor, 4'h1 << v[5:4])
        end

        // Every output source code of the decimation register
        for (int i = 0; i < 4; i++) begin
            v = {4'hc, i[1:0], 2'h1};
            wr_reg(ADDR_DECIM, v, 1'b0);
            rd_chk(ADDR_DECIM, {24'h0, v}, 1'b0);
            settle();
            `CHK(out_src_sel, v[3:2])
        end

        // Back to the preferred path before the unmapped probes
        wr_reg(ADDR_FILT, 8'h84, 1'b0);

        // Unmapped place: error, zero data, filter and decimation registers untouched
        wr_reg(12'h024, 8'hff, 1'b1);
        rd_chk(12'h024, 32'h0000_0000, 1'b1);
        rd_chk(ADDR_FILT, 32'h0000_0084, 1'b0);
        rd_chk(ADDR_DECIM, 32'h0000_00cd, 1'b0);

        // Reset in mid-run brings every field back to its default
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk_defaults();
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_FILT, 32'h0000_0004, 1'b0);
        rd_chk(ADDR_CLK, 32'h0000_0020, 1'b0);
        rd_chk(ADDR_DECIM, 32'h0000_00c5, 1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
